// file: include/rsc_pkg.sv
/*
 Constants for the reset source combiner: register offsets, cause bit positions,
 reset values and field layouts. Assumes a 16-bit register port with byte offsets.
*/
// How it works
// - Any active reset source drives the system reset line high.
// - System reset reloads selected register fields; other fields keep their value.
// - Each reset type sets its own flag in the reset cause register, except illegal opcode and uninitialised W register, which share bit 14.
// - Power-on clears cause register except power-on and brown-out flags, which set.
// - Software writes to the cause register store the written value, ORed with any flag that hardware sets in the same cycle.
// - Software-set cause flags never start a reset.
// - Every reset copies startup oscillator select into new oscillator field bits 10:8.
// - Cause bits 3..0 flag sleep wake, idle wake, brown-out, power-on.
package rsc_pkg;

    localparam int          DATA_W        = 16;
    localparam int          ADDR_W        = 8;
    localparam int          SYNC_W        = 2;

    // Register byte offsets
    localparam logic [7:0]  OFS_CAUSE     = 8'h00;
    localparam logic [7:0]  OFS_OSCCTL    = 8'h04;
    localparam logic [7:0]  OFS_IRQ_STAT  = 8'h08;
    localparam logic [7:0]  OFS_IRQ_MASK  = 8'h0C;

    // Reset cause register bit positions
    localparam int          BIT_POR       = 0;
    localparam int          BIT_BOR       = 1;
    localparam int          BIT_IDLE      = 2;
    localparam int          BIT_SLEEP     = 3;
    localparam int          BIT_WDT       = 4;
    localparam int          BIT_SWR       = 6;
    localparam int          BIT_MASTER_CLEAR_PIN      = 7;
    localparam int          BIT_CFGMM     = 9;
    localparam int          BIT_SEC       = 10;
    localparam int          BIT_ILLEGAL   = 14;
    localparam int          BIT_TRAP      = 15;

    // Synchroniser lane positions
    localparam int          SYN_BOR       = 0;
    localparam int          SYN_MASTER_CLEAR_PIN      = 1;

    // Oscillator control layout
    localparam int          NOSC_LSB      = 8;
    localparam int          NOSC_MSB      = 10;
    localparam int          NOSC_W        = 3;
    localparam int          OSC_USER_MSB  = 7;

    // Reset values and write masks
    localparam logic [15:0] CAUSE_POR_VAL = 16'h0003;
    localparam logic [15:0] OSC_RST_VAL   = 16'h0000;
    localparam logic [15:0] OSC_WR_MASK   = 16'h07FF;
    localparam logic [15:0] IRQ_RST_VAL   = 16'h0000;
    localparam logic [15:0] ZERO16        = 16'h0000;

endpackage : rsc_pkg

// file: rtl/rsc_sync.sv
/*
 Two-flop level synchroniser, one lane per bit.
 Assumes inputs are active-high levels from outside the clock domain.
*/
`timescale 1ns/1ps
module rsc_sync (
    input  wire logic                        clk_i,
    input  wire logic                        rst_n_i,
    input  wire logic [rsc_pkg::SYNC_W-1:0]  async_i,
    output logic      [rsc_pkg::SYNC_W-1:0]  sync_o
);

    logic [rsc_pkg::SYNC_W-1:0] meta_q;
    logic [rsc_pkg::SYNC_W-1:0] meta_d;
    logic [rsc_pkg::SYNC_W-1:0] sync_q;
    logic [rsc_pkg::SYNC_W-1:0] sync_d;

    genvar g;
    generate
        for (g = 0; g < rsc_pkg::SYNC_W; g++) begin : g_lane
            always_comb begin
                meta_d[g] = async_i[g];
                sync_d[g] = meta_q[g];
            end

            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    meta_q[g] <= 1'b0;
                    sync_q[g] <= 1'b0;
                end else begin
                    meta_q[g] <= meta_d[g];
                    sync_q[g] <= sync_d[g];
                end
            end
        end
    endgenerate

    assign sync_o = sync_q;

endmodule : rsc_sync

// file: rtl/rsc_irq.sv
/*
 Sticky interrupt status with write-one-to-clear, a mask and one level output.
 Assumes event bits come from logic on the same clock.
*/
`timescale 1ns/1ps
module rsc_irq (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [15:0] evt_i,
    input  wire logic        stat_we_i,
    input  wire logic        mask_we_i,
    input  wire logic [15:0] wdata_i,
    output logic      [15:0] stat_o,
    output logic      [15:0] mask_o,
    output logic             irq_o
);

    logic [15:0] stat_q;
    logic [15:0] stat_d;
    logic [15:0] mask_q;
    logic [15:0] mask_d;
    logic        irq_q;
    logic        irq_d;

    always_comb begin
        stat_d = stat_q;
        mask_d = mask_q;
        if (stat_we_i) begin
            stat_d = stat_q & ~wdata_i;
        end
        // Set beats clear so an event in the clearing cycle survives
        stat_d = stat_d | evt_i;
        if (mask_we_i) begin
            mask_d = wdata_i;
        end
        irq_d = |(stat_q & mask_q);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stat_q <= rsc_pkg::IRQ_RST_VAL;
            mask_q <= rsc_pkg::IRQ_RST_VAL;
            irq_q  <= 1'b0;
        end else begin
            stat_q <= stat_d;
            mask_q <= mask_d;
            irq_q  <= irq_d;
        end
    end

    assign stat_o = stat_q;
    assign mask_o = mask_q;
    assign irq_o  = irq_q;

    a_irq_set_wins : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (evt_i != 16'h0000) |=> ((stat_q & $past(evt_i)) == $past(evt_i)))
        else $error("interrupt event lost");

    a_irq_level : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ((stat_q & mask_q) != 16'h0000) |=> irq_o)
        else $error("interrupt output not raised");

endmodule : rsc_irq

// file: rtl/rsc_top.sv
/*
 Reset source combiner: merges reset sources into the system reset line, records
 reset causes, reloads the new oscillator field and raises a cause interrupt.
 Assumes rst_n_i is the power-on reset, brown-out and master clear are asynchronous,
 all other sources and the register port are on clk_i.
*/
`timescale 1ns/1ps
module rsc_top (
    input  wire logic                              clk_i,
    input  wire logic                              rst_n_i,
    input  wire logic                              brownout_reset_i,
    input  wire logic                              master_clear_pin_n_i,
    input  wire logic                              software_reset_instruction_i,
    input  wire logic                              watchdog_timeout_i,
    input  wire logic                              config_mismatch_i,
    input  wire logic                              trap_conflict_i,
    input  wire logic                              illegal_opcode_i,
    input  wire logic                              uninit_wreg_i,
    input  wire logic                              security_reset_i,
    input  wire logic                              wake_sleep_i,
    input  wire logic                              wake_idle_i,
    input  wire logic [rsc_pkg::NOSC_W-1:0]        startup_oscillator_select_i,
    input  wire logic [rsc_pkg::ADDR_W-1:0]        addr_i,
    input  wire logic [rsc_pkg::DATA_W-1:0]        wdata_i,
    input  wire logic                              we_i,
    input  wire logic                              re_i,
    output logic      [rsc_pkg::DATA_W-1:0]        rdata_o,
    output logic                                   system_reset_line_o,
    output logic      [rsc_pkg::NOSC_W-1:0]        new_oscillator_field_o,
    output logic                                   irq_o
);

    logic [rsc_pkg::SYNC_W-1:0] async_src;
    logic [rsc_pkg::SYNC_W-1:0] sync_src;
    logic                       bor_s;
    logic                       master_clear_pin_s;
    logic                       src_any;
    logic [15:0]                cause_set;
    logic [15:0]                cause_q;
    logic [15:0]                cause_d;
    logic [15:0]                osc_q;
    logic [15:0]                osc_d;
    logic                       sys_rst_q;
    logic                       sys_rst_d;
    logic [15:0]                rdata_q;
    logic [15:0]                rdata_d;
    logic [15:0]                irq_stat;
    logic [15:0]                irq_mask;
    logic                       wr_cause;
    logic                       wr_osc;
    logic                       wr_stat;
    logic                       wr_mask;
    logic                       first_q;

    // Inversion ahead of the first flop keeps the pin active high in the lanes
    assign async_src[rsc_pkg::SYN_BOR]  = brownout_reset_i;
    assign async_src[rsc_pkg::SYN_MASTER_CLEAR_PIN] = ~master_clear_pin_n_i;

    rsc_sync u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .async_i (async_src),
        .sync_o  (sync_src)
    );

    assign bor_s  = sync_src[rsc_pkg::SYN_BOR];
    assign master_clear_pin_s = sync_src[rsc_pkg::SYN_MASTER_CLEAR_PIN];

    assign wr_cause = we_i && (addr_i == rsc_pkg::OFS_CAUSE);
    assign wr_osc   = we_i && (addr_i == rsc_pkg::OFS_OSCCTL);
    assign wr_stat  = we_i && (addr_i == rsc_pkg::OFS_IRQ_STAT);
    assign wr_mask  = we_i && (addr_i == rsc_pkg::OFS_IRQ_MASK);

    // cause register stays out of this term
    always_comb begin
        src_any = bor_s | master_clear_pin_s | software_reset_instruction_i | watchdog_timeout_i
                | config_mismatch_i | trap_conflict_i | illegal_opcode_i
                | uninit_wreg_i | security_reset_i;
    end

    always_comb begin
        cause_set                       = rsc_pkg::ZERO16;
        cause_set[rsc_pkg::BIT_BOR]     = bor_s;
        cause_set[rsc_pkg::BIT_IDLE]    = wake_idle_i;
        cause_set[rsc_pkg::BIT_SLEEP]   = wake_sleep_i;
        cause_set[rsc_pkg::BIT_WDT]     = watchdog_timeout_i;
        cause_set[rsc_pkg::BIT_SWR]     = software_reset_instruction_i;
        cause_set[rsc_pkg::BIT_MASTER_CLEAR_PIN]    = master_clear_pin_s;
        cause_set[rsc_pkg::BIT_CFGMM]   = config_mismatch_i;
        cause_set[rsc_pkg::BIT_SEC]     = security_reset_i;
        cause_set[rsc_pkg::BIT_ILLEGAL] = illegal_opcode_i | uninit_wreg_i;
        cause_set[rsc_pkg::BIT_TRAP]    = trap_conflict_i;
    end

    // plain store of software writes
    // Hardware set wins so a source active during the write is not lost
    always_comb begin
        cause_d = cause_q;
        if (wr_cause) begin
            cause_d = wdata_i;
        end
        cause_d   = cause_d | cause_set;
        sys_rst_d = src_any;
    end

    // reset reloads only the new oscillator field
    always_comb begin
        osc_d = osc_q;
        if (wr_osc && !sys_rst_q) begin
            osc_d = wdata_i & rsc_pkg::OSC_WR_MASK;
        end
        if (sys_rst_q) begin
            osc_d[rsc_pkg::NOSC_MSB:rsc_pkg::NOSC_LSB] = startup_oscillator_select_i;
        end
    end

    // Read data only in the cycle after the strobe; unmapped reads give zero
    always_comb begin
        rdata_d = rsc_pkg::ZERO16;
        if (re_i) begin
            unique case (addr_i)
                rsc_pkg::OFS_CAUSE:    rdata_d = cause_q;
                rsc_pkg::OFS_OSCCTL:   rdata_d = osc_q;
                rsc_pkg::OFS_IRQ_STAT: rdata_d = irq_stat;
                rsc_pkg::OFS_IRQ_MASK: rdata_d = irq_mask;
                default:               rdata_d = rsc_pkg::ZERO16;
            endcase
        end
    end

    // power-on value of the cause register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cause_q   <= rsc_pkg::CAUSE_POR_VAL;
            osc_q     <= rsc_pkg::OSC_RST_VAL;
            sys_rst_q <= 1'b1;
            rdata_q   <= rsc_pkg::ZERO16;
            first_q   <= 1'b1;
        end else begin
            cause_q   <= cause_d;
            osc_q     <= osc_d;
            sys_rst_q <= sys_rst_d;
            rdata_q   <= rdata_d;
            first_q   <= 1'b0;
        end
    end

    // Interrupt reports every recorded cause event except power-on
    rsc_irq u_irq (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .evt_i     (cause_set),
        .stat_we_i (wr_stat),
        .mask_we_i (wr_mask),
        .wdata_i   (wdata_i),
        .stat_o    (irq_stat),
        .mask_o    (irq_mask),
        .irq_o     (irq_o)
    );

    assign rdata_o                = rdata_q;
    assign system_reset_line_o    = sys_rst_q;
    assign new_oscillator_field_o = osc_q[rsc_pkg::NOSC_MSB:rsc_pkg::NOSC_LSB];

    a_reset_any_source : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        src_any |=> system_reset_line_o)
        else $error("source active but no system reset");

    a_reset_released : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !src_any |=> !system_reset_line_o)
        else $error("system reset without source");

    a_user_field_kept : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sys_rst_q |=> (osc_q[7:0] == $past(osc_q[7:0])))
        else $error("oscillator user field changed in reset");

    a_cause_flag_set : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (cause_set != 16'h0000) |=> ((cause_q & $past(cause_set)) == $past(cause_set)))
        else $error("reset cause flag not recorded");

    a_por_cause_value : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        first_q |-> (cause_q == 16'h0003))
        else $error("power-on cause value wrong");

    a_cause_write_store : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_cause && (cause_set == 16'h0000)) |=> (cause_q == $past(wdata_i)))
        else $error("cause write not stored");

    a_sw_flag_no_reset : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_cause && !src_any) |=> !system_reset_line_o)
        else $error("software cause write caused reset");

    a_nosc_loaded : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sys_rst_q |=> (new_oscillator_field_o == $past(startup_oscillator_select_i)))
        else $error("new oscillator field not loaded");

    a_wake_flags : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wake_sleep_i || wake_idle_i) |=>
        ((!$past(wake_sleep_i) || cause_q[3]) && (!$past(wake_idle_i) || cause_q[2])))
        else $error("wake flag not set");

    a_master_clear_pin_sync_flag : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!master_clear_pin_n_i)[*3] |=> cause_q[7])
        else $error("master clear not flagged after sync");

    // A software write may set the flag on purpose, so such cycles are left out
    a_master_clear_pin_sync_delay : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (master_clear_pin_n_i && !cause_q[7] && !wr_cause)[*3] |=> !cause_q[7])
        else $error("master clear flagged without pin");

    a_master_clear_pin_reset_line : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!master_clear_pin_n_i)[*3] |=> system_reset_line_o)
        else $error("master clear did not reset");

    a_bor_reset_line : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        brownout_reset_i[*3] |=> system_reset_line_o)
        else $error("brown-out did not reset");

    a_bor_sync_flag : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        brownout_reset_i[*3] |=> cause_q[rsc_pkg::BIT_BOR])
        else $error("brown-out not flagged after sync");

    a_wdt_flag_set : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        watchdog_timeout_i |=> cause_q[rsc_pkg::BIT_WDT])
        else $error("watchdog flag not set");

    a_swr_flag_set : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        software_reset_instruction_i |=> cause_q[rsc_pkg::BIT_SWR])
        else $error("reset instruction flag not set");

    a_cfg_flag_set : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        config_mismatch_i |=> cause_q[rsc_pkg::BIT_CFGMM])
        else $error("config mismatch flag not set");

    a_sec_flag_set : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        security_reset_i |=> cause_q[rsc_pkg::BIT_SEC])
        else $error("security flag not set");

    a_ill_flag_set : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (illegal_opcode_i || uninit_wreg_i) |=> cause_q[rsc_pkg::BIT_ILLEGAL])
        else $error("illegal condition flag not set");

    a_trap_flag_set : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        trap_conflict_i |=> cause_q[rsc_pkg::BIT_TRAP])
        else $error("trap conflict flag not set");

    a_cause_kept : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!wr_cause && (cause_set == 16'h0000)) |=> (cause_q == $past(cause_q)))
        else $error("cause register changed by itself");

    a_rdata_idle : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !re_i |=> (rdata_o == 16'h0000))
        else $error("read data outside read cycle");

    a_cause_read : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (re_i && (addr_i == rsc_pkg::OFS_CAUSE)) |=> (rdata_o == $past(cause_q)))
        else $error("cause read wrong");

    a_osc_read : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (re_i && (addr_i == rsc_pkg::OFS_OSCCTL)) |=> (rdata_o == $past(osc_q)))
        else $error("oscillator control read wrong");

    a_osc_write : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_osc && !sys_rst_q) |=> (osc_q == ($past(wdata_i) & 16'h07FF)))
        else $error("oscillator control write not stored");

    a_osc_top_zero : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        1'b1 |-> (osc_q[15:11] == 5'h00))
        else $error("oscillator control upper bits set");

    a_stat_read : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (re_i && (addr_i == rsc_pkg::OFS_IRQ_STAT)) |=> (rdata_o == $past(irq_stat)))
        else $error("interrupt status read wrong");

    a_mask_read : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (re_i && (addr_i == rsc_pkg::OFS_IRQ_MASK)) |=> (rdata_o == $past(irq_mask)))
        else $error("interrupt mask read wrong");

endmodule : rsc_top

// file: sim/rsc_src_model.sv
/*
 Model of the on-chip reset sources: raises one chosen source as a level for a set
 number of cycles. Assumes fire_i is a one-cycle request on clk_i.
*/
`timescale 1ns/1ps
module rsc_src_model (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       fire_i,
    input  wire logic [3:0] sel_i,
    input  wire logic [2:0] len_i,
    output logic      [7:0] src_o,
    output logic            master_clear_pin_n_o
);
    logic [8:0] src_q;
    logic [2:0] cnt_q;

    // Hold length varies, so both short and long source pulses occur
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            src_q <= 9'h000;
            cnt_q <= 3'h0;
        end else if (fire_i) begin
            src_q <= 9'h001 << sel_i;
            cnt_q <= len_i;
        end else if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q - 3'h1;
            if (cnt_q == 3'h1) begin
                src_q <= 9'h000;
            end
        end
    end

    assign src_o    = src_q[7:0];
    // Pin lane is active low
    assign master_clear_pin_n_o = ~src_q[8];
endmodule : rsc_src_model

// file: sim/test_rsc_top.sv
/*
 Self-checking bench for the reset source combiner: register reads, every source, wakes,
 oscillator reload and the cause interrupt. Assumes rsc_pkg and the source model.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
    $display("mismatch t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module test_rsc_top;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [7:0]  addr_i = 8'h00;
    logic [15:0] wdata_i = 16'h0000;
    logic        we_i = 1'b0;
    logic        re_i = 1'b0;
    logic        wk_sleep = 1'b0;
    logic        wk_idle = 1'b0;
    logic [2:0]  osel = 3'h0;
    logic        fire = 1'b0;
    logic [3:0]  fsel = 4'h0;
    logic [2:0]  flen = 3'h1;
    logic [7:0]  src;
    logic        master_clear_pin_n;
    logic [15:0] rdata_o;
    logic        system_reset_line_o;
    logic [2:0]  new_oscillator_field_o;
    logic        irq_o;
    logic        rd_pend = 1'b0;
    logic [15:0] exp_v;
    logic [15:0] exp_q [$];
    int          bad_count = 0;
    int          check_count = 0;
    int          bit_tab [9] = '{rsc_pkg::BIT_SWR, rsc_pkg::BIT_WDT, rsc_pkg::BIT_CFGMM,
        rsc_pkg::BIT_TRAP, rsc_pkg::BIT_ILLEGAL, rsc_pkg::BIT_ILLEGAL, rsc_pkg::BIT_SEC,
        rsc_pkg::BIT_BOR, rsc_pkg::BIT_MASTER_CLEAR_PIN};

    rsc_src_model srcm (.clk_i(clk_i), .rst_n_i(rst_n_i), .fire_i(fire), .sel_i(fsel),
        .len_i(flen), .src_o(src), .master_clear_pin_n_o(master_clear_pin_n));

    rsc_top uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .brownout_reset_i(src[7]),
        .master_clear_pin_n_i(master_clear_pin_n), .software_reset_instruction_i(src[0]),
        .watchdog_timeout_i(src[1]), .config_mismatch_i(src[2]), .trap_conflict_i(src[3]),
        .illegal_opcode_i(src[4]), .uninit_wreg_i(src[5]), .security_reset_i(src[6]),
        .wake_sleep_i(wk_sleep), .wake_idle_i(wk_idle), .startup_oscillator_select_i(osel),
        .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
        .system_reset_line_o(system_reset_line_o),
        .new_oscillator_field_o(new_oscillator_field_o), .irq_o(irq_o));

    always #5 clk_i = ~clk_i;

    // Read data stand only in the cycle after the strobe
    always @(posedge clk_i) rd_pend <= re_i;
    always @(negedge clk_i) begin
        if (rd_pend) begin
            exp_v = exp_q.pop_front();
            `CHK(rdata_o, exp_v)
        end
    end

    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // Idle cycle after each strobe keeps every signal to one assignment per step
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        we_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        re_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        re_i <= 1'b0;
        @(posedge clk_i);
    endtask : rd

    task automatic wait_line(input logic lvl, output int n);
        bit found;
        found = 1'b0;
        n = -1;
        for (int i = 0; i < 40 && !found; i++) begin
            @(negedge clk_i);
            found = (system_reset_line_o === lvl);
            if (found) n = i;
        end
        if (!found) begin
            bad_count++;
            report_and_stop();
        end
        @(posedge clk_i);
    endtask : wait_line

    // Brown-out and master clear pin sources reach the line two cycles later than clocked ones
    task automatic fire_src(input int s);
        int n;
        fire <= 1'b1;
        fsel <= 4'(s);
        flen <= 3'($urandom_range(1, 6));
        @(posedge clk_i);
        fire <= 1'b0;
        wait_line(1'b1, n);
        `CHK(n, (s >= 7) ? 3 : 1)
        wait_line(1'b0, n);
    endtask : fire_src

    initial begin
        logic [15:0] d;
        void'($urandom(33));
        osel = 3'($urandom);
        repeat (5) @(posedge clk_i);
        #1 `CHK(system_reset_line_o, 1'b1)
        repeat (7) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rd(8'h00, rsc_pkg::CAUSE_POR_VAL);
        rd(8'h04, {5'h00, osel, 8'h00});
        rd(8'h10, 16'h0000);
        for (int k = 0; k < 2; k++) begin
            d = k ? 16'hFFFF : 16'($urandom);
            wr(8'h00, d);
            repeat (4) begin
                @(negedge clk_i);
                `CHK(system_reset_line_o, 1'b0)
            end
            @(posedge clk_i);
            rd(8'h00, d);
        end
        wr(8'h00, 16'h0000);
        wr(8'h04, 16'h00A5);
        for (int s = 0; s < 9; s++) begin
            osel <= 3'($urandom);
            fire_src(s);
            rd(8'h00, 16'h0001 << bit_tab[s]);
            rd(8'h04, {5'h00, osel, 8'hA5});
            `CHK(new_oscillator_field_o, osel)
            // Clearing after reading keeps the next cause reading clean
            wr(8'h00, 16'h0000);
        end
        wk_sleep <= 1'b1;
        @(posedge clk_i);
        wk_sleep <= 1'b0;
        wk_idle <= 1'b1;
        @(posedge clk_i);
        wk_idle <= 1'b0;
        @(negedge clk_i);
        `CHK(system_reset_line_o, 1'b0)
        @(posedge clk_i);
        rd(8'h00, 16'h000C);
        wr(8'h08, 16'hFFFF);
        wr(8'h0C, 16'h0010);
        fire_src(6);
        repeat (2) @(posedge clk_i);
        `CHK(irq_o, 1'b0)
        fire_src(1);
        repeat (2) @(posedge clk_i);
        `CHK(irq_o, 1'b1)
        wr(8'h08, 16'h0010);
        repeat (2) @(posedge clk_i);
        `CHK(irq_o, 1'b0)
        report_and_stop();
    end
endmodule : test_rsc_top
